// ===== rtl/rsm_pkg.sv
// Operation
// R1: the two-bit clear-channel rule picks always clear, clear below threshold, clear unless receiving, or both conditions.
// R2: after a packet is received the state moves to idle, transmit-synth-on, transmit or stays in receive as the post-receive field says.
// R3: software must not pair a post-receive of transmit or transmit-synth-on with clear-channel assessment.
// R4: after a packet is sent the state moves to idle, transmit-synth-on, stays in transmit or goes to receive as the post-transmit field says.
// R5: staying in transmit restarts preamble as soon as the previous packet ends.
// R6: auto-calibration 00 never calibrates by itself; only the manual calibrate strobe does.
// R7: auto-calibration 01 calibrates on every step from idle into receive, transmit or transmit-synth-on.
// R8: auto-calibration 10 calibrates on every return from receive or transmit to idle.
// R9: auto-calibration 11 calibrates on every fourth return from receive or transmit to idle.
// R10: the power-on field sets 1, 16, 64 or 256 expiries of a six-bit ripple counter before chip ready goes low.
// R11: the pin-control bit lets pins steer the radio state as well as strobes.
// R12: the oscillator force-on bit keeps the crystal oscillator running in sleep.
// R13: calibrating every fourth return to idle is advised for low current in wake-on-radio use.
// R14: the two reserved upper bits of both registers read zero and ignore writes.
package rsm_pkg;
	localparam logic [7:0] ADDR_END_STATE = 8'h17;
	localparam logic [7:0] ADDR_CAL_POWER = 8'h18;
	localparam logic [7:0] RST_END_STATE  = 8'h30;
	localparam logic [7:0] RST_CAL_POWER  = 8'h04;
	localparam logic [7:0] WR_MASK        = 8'h3F;
	localparam int RIPPLE_W   = 6;
	localparam int EXPIRY_W   = 9;
	localparam int CAL_EVERY  = 4;

	typedef enum logic [2:0] {
		ST_SLEEP, ST_IDLE, ST_FSTX, ST_RX, ST_TX, ST_CAL
	} rsm_radio_e;

	typedef struct packed {
		logic        strobe_idle;
		logic        strobe_rx;
		logic        strobe_tx;
		logic        strobe_fstx;
		logic        strobe_sleep;
		logic        strobe_cal;
	} rsm_cmd_s;

	typedef struct packed {
		logic        rssi_below;
		logic        receiving;
		logic        rx_done;
		logic        tx_done;
		logic        cal_done;
	} rsm_radio_in_s;

	function automatic logic [EXPIRY_W-1:0] expiry_target(input logic [1:0] sel);
		case (sel)
			2'b00:   expiry_target = 9'd1;
			2'b01:   expiry_target = 9'd16;
			2'b10:   expiry_target = 9'd64;
			default: expiry_target = 9'd256;
		endcase
	endfunction
endpackage

// ===== rtl/rsm_regs.sv
module rsm_regs
	import rsm_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] end_state_o,
	output logic      [7:0] cal_power_o,
	output logic      [7:0] rdata_o
);
	typedef struct packed {
		logic [7:0] end_state;
		logic [7:0] cal_power;
		logic [7:0] rdata;
	} rsm_regs_s;

	rsm_regs_s st_r;
	rsm_regs_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdata = 8'h00;
		if (wr_i && addr_i == ADDR_END_STATE)
			st_nxt.end_state = wdata_i & WR_MASK; // see R14
		if (wr_i && addr_i == ADDR_CAL_POWER)
			st_nxt.cal_power = wdata_i & WR_MASK; // see R14
		if (rd_i)
		begin
			case (addr_i)
				ADDR_END_STATE: st_nxt.rdata = st_r.end_state;
				ADDR_CAL_POWER: st_nxt.rdata = st_r.cal_power;
				default:        st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_r <= '{end_state: RST_END_STATE, cal_power: RST_CAL_POWER, rdata: 8'h00};
		else
			st_r <= st_nxt;
	end

	assign end_state_o = st_r.end_state;
	assign cal_power_o = st_r.cal_power;
	assign rdata_o     = st_r.rdata;
endmodule

// ===== rtl/rsm_power_on.sv
module rsm_power_on
	import rsm_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	input  wire logic       osc_run_i,
	input  wire logic [1:0] expiry_sel_i,
	output logic            chip_ready_low_o
);
	typedef struct packed {
		logic [RIPPLE_W-1:0] ripple;
		logic [EXPIRY_W-1:0] expiries;
		logic                ready_n;
	} rsm_po_s;

	rsm_po_s st_r;
	rsm_po_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (!osc_run_i)
		begin
			// oscillator stopped: restart the timeout on next start
			st_nxt.ripple   = '0;
			st_nxt.expiries = '0;
			st_nxt.ready_n  = 1'b1;
		end
		else if (st_r.ready_n)
		begin
			st_nxt.ripple = st_r.ripple + 1'b1;
			if (&st_r.ripple)
			begin
				st_nxt.expiries = st_r.expiries + 1'b1;
				if (st_r.expiries + 1'b1 >= expiry_target(expiry_sel_i))
					st_nxt.ready_n = 1'b0; // see R10
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_r <= '{ripple: '0, expiries: '0, ready_n: 1'b1};
		else
			st_r <= st_nxt;
	end

	assign chip_ready_low_o = st_r.ready_n;
endmodule

// ===== rtl/rsm_top.sv
// Local design decision: the plain strobed port.
module rsm_top
	import rsm_pkg::*;
(
	input  wire logic                   mclk_i,
	input  wire logic                   arst_n_i,
	input  wire logic [7:0]             addr_i,
	input  wire logic [7:0]             wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [7:0]             rdata_o,
	input  rsm_pkg::rsm_cmd_s           strobe_i,
	input  rsm_pkg::rsm_cmd_s           pin_cmd_i,
	input  rsm_pkg::rsm_radio_in_s      radio_i,
	output rsm_pkg::rsm_radio_e         state_o,
	output logic                        clear_channel_o,
	output logic                        cal_start_o,
	output logic                        preamble_start_o,
	output logic                        osc_run_o,
	output logic                        chip_ready_low_o
);
	logic [7:0] end_state;
	logic [7:0] cal_power;

	rsm_regs u_regs (
		.mclk_i      (mclk_i),
		.arst_n_i    (arst_n_i),
		.addr_i      (addr_i),
		.wdata_i     (wdata_i),
		.wr_i        (wr_i),
		.rd_i        (rd_i),
		.end_state_o (end_state),
		.cal_power_o (cal_power),
		.rdata_o     (rdata_o)
	);

	logic [1:0] cca_rule;
	logic [1:0] post_rx;
	logic [1:0] post_tx;
	logic [1:0] auto_cal;
	logic [1:0] po_sel;
	logic       pin_ctrl_en;
	logic       osc_force_on;

	assign cca_rule     = end_state[5:4];
	assign post_rx      = end_state[3:2];
	assign post_tx      = end_state[1:0];
	assign auto_cal     = cal_power[5:4];
	assign po_sel       = cal_power[3:2];
	assign pin_ctrl_en  = cal_power[1];
	assign osc_force_on = cal_power[0];

	typedef struct packed {
		rsm_radio_e state;
		rsm_radio_e after_cal;
		logic [1:0] idle_returns;
		logic       clear;
		logic       cal_start;
		logic       preamble;
		logic       osc_run;
	} rsm_top_s;

	rsm_top_s  st_r;
	rsm_top_s  st_nxt;
	rsm_cmd_s  cmd;
	logic      to_idle;

	// pins only count while pin control is enabled
	assign cmd = strobe_i | (pin_ctrl_en ? pin_cmd_i : '0); // see R11

	always_comb
	begin
		st_nxt           = st_r;
		st_nxt.cal_start = 1'b0;
		st_nxt.preamble  = 1'b0;
		to_idle          = 1'b0;

		case (cca_rule) // see R1
			2'b00:   st_nxt.clear = 1'b1;
			2'b01:   st_nxt.clear = radio_i.rssi_below;
			2'b10:   st_nxt.clear = !radio_i.receiving;
			default: st_nxt.clear = radio_i.rssi_below && !radio_i.receiving;
		endcase

		case (st_r.state)
			ST_SLEEP:
			begin
				if (cmd.strobe_idle)
					st_nxt.state = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (cmd.strobe_cal)
				begin
					st_nxt.state     = ST_CAL; // see R6
					st_nxt.after_cal = ST_IDLE;
					st_nxt.cal_start = 1'b1;
				end
				else if (cmd.strobe_rx || cmd.strobe_tx || cmd.strobe_fstx)
				begin
					if (cmd.strobe_rx)
						st_nxt.after_cal = ST_RX;
					else if (cmd.strobe_tx)
						st_nxt.after_cal = ST_TX;
					else
						st_nxt.after_cal = ST_FSTX;
					if (auto_cal == 2'b01)
					begin
						st_nxt.state     = ST_CAL; // see R7
						st_nxt.cal_start = 1'b1;
					end
					else
					begin
						st_nxt.state    = st_nxt.after_cal;
						st_nxt.preamble = cmd.strobe_tx;
					end
				end
				else if (cmd.strobe_sleep)
					st_nxt.state = ST_SLEEP;
			end
			ST_CAL:
			begin
				if (radio_i.cal_done)
				begin
					st_nxt.state    = st_r.after_cal;
					st_nxt.preamble = (st_r.after_cal == ST_TX);
				end
			end
			ST_FSTX:
			begin
				if (cmd.strobe_idle)
					st_nxt.state = ST_IDLE;
				else if (cmd.strobe_tx)
				begin
					st_nxt.state    = ST_TX;
					st_nxt.preamble = 1'b1;
				end
			end
			ST_RX:
			begin
				if (cmd.strobe_idle)
					to_idle = 1'b1;
				else if (radio_i.rx_done)
				begin
					case (post_rx) // see R2
						2'b00:   to_idle = 1'b1;
						2'b01:   st_nxt.state = ST_FSTX;
						2'b10:
						begin
							st_nxt.state    = ST_TX;
							st_nxt.preamble = 1'b1;
						end
						default: st_nxt.state = ST_RX;
					endcase
				end
			end
			ST_TX:
			begin
				if (cmd.strobe_idle)
					to_idle = 1'b1;
				else if (radio_i.tx_done)
				begin
					case (post_tx) // see R4
						2'b00:   to_idle = 1'b1;
						2'b01:   st_nxt.state = ST_FSTX;
						2'b10:   st_nxt.preamble = 1'b1; // see R5
						default: st_nxt.state = ST_RX;
					endcase
				end
			end
			default: st_nxt.state = ST_IDLE;
		endcase

		if (to_idle)
		begin
			st_nxt.after_cal = ST_IDLE;
			st_nxt.state     = ST_IDLE;
			if (auto_cal == 2'b10)
			begin
				st_nxt.state     = ST_CAL; // see R8
				st_nxt.cal_start = 1'b1;
			end
			else if (auto_cal == 2'b11)
			begin
				st_nxt.idle_returns = st_r.idle_returns + 2'd1; // see R9
				if (st_r.idle_returns == 2'(CAL_EVERY - 1))
				begin
					st_nxt.state     = ST_CAL;
					st_nxt.cal_start = 1'b1;
				end
			end
		end

		// oscillator stops in sleep unless forced on
		st_nxt.osc_run = (st_nxt.state != ST_SLEEP) || osc_force_on; // see R12
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_r <= '{state: ST_IDLE, after_cal: ST_IDLE, idle_returns: 2'd0,
				clear: 1'b1, cal_start: 1'b0, preamble: 1'b0, osc_run: 1'b1};
		else
			st_r <= st_nxt;
	end

	rsm_power_on u_power_on (
		.mclk_i           (mclk_i),
		.arst_n_i         (arst_n_i),
		.osc_run_i        (st_r.osc_run),
		.expiry_sel_i     (po_sel),
		.chip_ready_low_o (chip_ready_low_o)
	);

	assign state_o          = st_r.state;
	assign clear_channel_o  = st_r.clear;
	assign cal_start_o      = st_r.cal_start;
	assign preamble_start_o = st_r.preamble;
	assign osc_run_o        = st_r.osc_run;
endmodule

// ===== test/rsm_chk.sv
module rsm_chk
	import rsm_pkg::*;
(
	input wire logic                   mclk_i,
	input wire logic                   arst_n_i,
	input wire logic [7:0]             addr_i,
	input wire logic [7:0]             wdata_i,
	input wire logic                   wr_i,
	input wire logic                   rd_i,
	input wire logic [7:0]             rdata_o,
	input wire rsm_pkg::rsm_cmd_s      strobe_i,
	input wire rsm_pkg::rsm_cmd_s      pin_cmd_i,
	input wire rsm_pkg::rsm_radio_in_s radio_i,
	input wire rsm_pkg::rsm_radio_e    state_o,
	input wire logic                   clear_channel_o,
	input wire logic                   cal_start_o,
	input wire logic                   preamble_start_o,
	input wire logic                   osc_run_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	logic [7:0] m1_r, m0_r;
	logic       cc_r;
	logic       idle_cmd;

	// an idle command beats a packet-end event, from strobes or enabled pins
	assign idle_cmd = strobe_i.strobe_idle || (m0_r[1] && pin_cmd_i.strobe_idle);

	// shadow copies of both registers, so no design internals are needed
	always_ff @(posedge mclk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			m1_r <= 8'h30;
			m0_r <= 8'h04;
			cc_r <= 1'h1;
		end
		else
		begin
			cc_r <= (!m1_r[4] || radio_i.rssi_below) && (!m1_r[5] || !radio_i.receiving);
			if (wr_i && addr_i == 8'h17)
				m1_r <= wdata_i;
			if (wr_i && addr_i == 8'h18)
				m0_r <= wdata_i;
		end

	chk_clear_rule: assert property (clear_channel_o == cc_r)
		else $error("clear flag wrong");
	chk_rx_next: assert property (state_o == ST_RX && radio_i.rx_done && m1_r[3:2] != 0
		&& !idle_cmd
		|=> state_o == ($past(m1_r[2]) ? ($past(m1_r[3]) ? ST_RX : ST_FSTX) : ST_TX))
		else $error("bad state after receive");
	chk_tx_repeat: assert property (state_o == ST_TX && radio_i.tx_done && m1_r[1:0] == 2'h2
		&& !idle_cmd
		|=> preamble_start_o && state_o == ST_TX) else $error("no preamble restart");
	chk_no_autocal: assert property (m0_r[5:4] == 0 && !m0_r[1] && !strobe_i.strobe_cal
		|=> !cal_start_o) else $error("unexpected calibration");
	chk_cal_entry: assert property (m0_r[5:4] == 2'h1 && state_o == ST_IDLE && strobe_i.strobe_rx
		|=> cal_start_o && state_o == ST_CAL) else $error("no calibration on entry");
	chk_cal_return: assert property (m0_r[5:4] == 2'h2 && state_o == ST_RX && strobe_i.strobe_idle
		|=> cal_start_o) else $error("no calibration on return");
	chk_osc_sleep: assert property (state_o == ST_SLEEP && m0_r[0] |=> osc_run_o)
		else $error("oscillator stopped");
	chk_read_back: assert property (rd_i
		|=> rdata_o == (($past(addr_i) == 8'h17 ? $past(m1_r)
			: $past(addr_i) == 8'h18 ? $past(m0_r) : 8'h00) & 8'h3F))
		else $error("bad read data");
endmodule

bind rsm_top rsm_chk chk_u (.*);

// ===== test/radio_state_machine_config_tb.sv
module radio_state_machine_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rsm_pkg::*;
	localparam logic [5:0] IDL = 6'h20, RXS = 6'h10, TXS = 6'h08, SLP = 6'h02, CAL = 6'h01;
	logic          mclk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0;
	logic [7:0]    addr_i = 0, wdata_i = 0, rdata_o;
	rsm_cmd_s      strobe_i = 0, pin_cmd_i = 0;
	rsm_radio_in_s radio_i = 0;
	rsm_radio_e    state_o;
	logic          clear_channel_o, cal_start_o, preamble_start_o, osc_run_o, chip_ready_low_o;
	int            bad_count = 0, total_checks = 0;
	// rule, strength below, receiving, expected clear
	logic [4:0]    rows[8] = '{5'h03, 5'h08, 5'h0D, 5'h16, 5'h11, 5'h1D, 5'h1E, 5'h18};
	rsm_radio_e    nx[4] = '{ST_IDLE, ST_FSTX, ST_TX, ST_RX};

	rsm_top dut_u (.mclk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .strobe_i,
		.pin_cmd_i, .radio_i, .state_o, .clear_channel_o, .cal_start_o, .preamble_start_o,
		.osc_run_o, .chip_ready_low_o);

	initial
		forever #5 mclk_i = ~mclk_i;

	task automatic chk(input logic [7:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rst;
		arst_n_i <= 0;
		repeat (3) @(posedge mclk_i);
		arst_n_i <= 1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge mclk_i);
		wr_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge mclk_i);
		rd_i <= 0;
		#1 chk(rdata_o, e);
	endtask
	// one cycle of command and event pulses, then the state that should follow
	task automatic go(input logic [5:0] c, p, input logic [4:0] r, input rsm_radio_e e);
		@(posedge mclk_i);
		strobe_i <= c;
		pin_cmd_i <= p;
		radio_i <= r;
		@(posedge mclk_i);
		strobe_i <= 0;
		pin_cmd_i <= 0;
		radio_i <= 0;
		#1 chk(state_o, e);
	endtask

	initial
	begin
		rst();
		rd(8'h17, 8'h30);
		rd(8'h18, 8'h04);
		rd(8'h20, 8'h00);
		wr(8'h17, 8'hFF);
		rd(8'h17, 8'h3F);
		foreach (rows[i])
		begin
			wr(8'h17, {2'h0, rows[i][4:3], 4'h0});
			radio_i <= {rows[i][2:1], 3'h0};
			repeat (2) @(posedge mclk_i);
			#1 chk(clear_channel_o, rows[i][0]);
		end
		$display("registers and clear rule end");
		for (int k = 0; k < 4; k++)
		begin
			// clear rule held at always-clear while post-receive may pick transmit
			wr(8'h17, {4'h0, k[1:0], k[1:0]});
			go(RXS, 0, 0, ST_RX);
			go(0, 0, 5'h04, nx[k]);
			go(IDL, 0, 0, ST_IDLE);
			go(TXS, 0, 0, ST_TX);
			go(0, 0, 5'h02, nx[k]);
			chk(preamble_start_o, k == 2);
			go(IDL, 0, 0, ST_IDLE);
		end
		wr(8'h18, 8'h14);
		go(RXS, 0, 0, ST_CAL);
		chk(cal_start_o, 1);
		go(0, 0, 5'h01, ST_RX);
		go(IDL, 0, 0, ST_IDLE);
		wr(8'h18, 8'h24);
		go(RXS, 0, 0, ST_RX);
		go(IDL, 0, 0, ST_CAL);
		chk(cal_start_o, 1);
		go(0, 0, 5'h01, ST_IDLE);
		// every-fourth calibration, the low-current choice for wake-on-radio
		wr(8'h18, 8'h34);
		for (int i = 0; i < 4; i++)
		begin
			go(RXS, 0, 0, ST_RX);
			go(IDL, 0, 0, i == 3 ? ST_CAL : ST_IDLE);
		end
		go(0, 0, 5'h01, ST_IDLE);
		wr(8'h18, 8'h04);
		go(RXS, 0, 0, ST_RX);
		go(IDL, 0, 0, ST_IDLE);
		go(CAL, 0, 0, ST_CAL);
		go(0, 0, 5'h01, ST_IDLE);
		go(0, RXS, 0, ST_IDLE);
		wr(8'h18, 8'h06);
		go(0, RXS, 0, ST_RX);
		go(0, IDL, 0, ST_IDLE);
		wr(8'h18, 8'h05);
		go(SLP, 0, 0, ST_SLEEP);
		// two edges so the sleep assertion completes before the next reset
		repeat (2) @(posedge mclk_i);
		#1 chk(osc_run_o, 1);
		rst();
		go(SLP, 0, 0, ST_SLEEP);
		@(posedge mclk_i);
		#1 chk(osc_run_o, 0);
		$display("state and calibration end");
		// ready window allows a few cycles of slack for the write after reset
		for (int j = 0; j < 4; j++)
		begin
			rst();
			wr(8'h18, {4'h0, j[1:0], 2'h0});
			repeat (64 * (j == 0 ? 1 : 1 << (2 * j + 2)) - 8) @(posedge mclk_i);
			#1 chk(chip_ready_low_o, 1);
			repeat (16) @(posedge mclk_i);
			#1 chk(chip_ready_low_o, 0);
		end
		$display("power-on end");
		stop_test();
	end

	initial
	begin
		#400000;
		bad_count++;
		stop_test();
	end
endmodule
